// File: axis_host_model.sv
// Purpose: Host processor driving the byte register port.
// Assumes: Tasks are entered on a falling clock edge.
// Notes: Strobes stay up across back-to-back calls; idle drops them.
`timescale 1ns/1ps
`default_nettype none
module axis_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Quiet port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // One write, held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    @(negedge clk_sys);
  endtask
  // One read; data is registered by the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // Drop strobes and scramble released lines
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(negedge clk_sys);
  endtask
  // After a pin asserts, ask which sources are pending
  task automatic service(output logic [7:0] src);
    rd(8'h0c, src);
  endtask
endmodule
`default_nettype wire

// File: axis_offset_checker.sv
// Purpose: Port assertions for the axis offset register map.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every instance of the register map.
`timescale 1ns/1ps
`default_nettype none
module axis_offset_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Settings and pins
  input wire logic [7:0] wake_enables,
  input wire logic first_irq_pin_out,
  input wire logic first_irq_pin_oe,
  input wire logic second_irq_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Trim written then read back at the same offset
  chk_trim_readback: assert property (
    (clk_en && reg_wr && reg_addr >= 8'h2f && reg_addr <= 8'h31) ##1
    (clk_en && reg_rd && !reg_wr && reg_addr == $past(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("trim read back differs from write");
  // Low sample bytes keep their six pad bits clear
  chk_low_pad: assert property (
    clk_en && reg_rd && (reg_addr == 8'h02 || reg_addr == 8'h04 ||
    reg_addr == 8'h06) |=> reg_rdata[5:0] == 6'h00)
    else $error("low sample byte pad bits not zero");
  // Enable, routing and pending maps leave bits 6 and 1 clear
  chk_map_reserved: assert property (
    clk_en && reg_rd && (reg_addr == 8'h0c || reg_addr == 8'h2d ||
    reg_addr == 8'h2e) |=> !reg_rdata[6] && !reg_rdata[1])
    else $error("interrupt map reserved bit set");
  // Wake copy follows a write two edges later
  chk_wake_copy: assert property (
    clk_en && reg_wr && reg_addr == 8'h2c ##1 clk_en
    |=> wake_enables == ($past(reg_wdata, 2) & 8'h7b))
    else $error("wake copy does not follow write");
  // Wake copy never shows its reserved bits
  chk_wake_reserved: assert property (
    !wake_enables[7] && !wake_enables[2])
    else $error("wake copy reserved bit set");
  // Push-pull drive keeps both pins enabled
  chk_pushpull_oe: assert property (
    !wake_enables[0] && $stable(wake_enables)
    |-> first_irq_pin_oe && second_irq_pin_oe)
    else $error("push-pull pin not driven");
  // Open drain drives only the active level
  chk_opendrain_level: assert property (
    wake_enables[0] && $stable(wake_enables) && first_irq_pin_oe
    |-> first_irq_pin_out == wake_enables[1])
    else $error("open drain pin drives idle level");
  // Read data holds between taken reads
  chk_read_hold: assert property (
    !(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule
bind axis_offset_register_map axis_offset_checker chk_i (
  .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wake_enables(wake_enables),
  .first_irq_pin_out(first_irq_pin_out),
  .first_irq_pin_oe(first_irq_pin_oe),
  .second_irq_pin_oe(second_irq_pin_oe));
`default_nettype wire

// File: axis_offset_consts.svh
// Purpose: Register offsets, field positions, masks and reset values.
// Assumes: Byte-wide registers on an 8-bit register address.
// Notes: Definitions only; included by the register map and trim adder.
`ifndef AXIS_OFFSET_CONSTS_SVH
`define AXIS_OFFSET_CONSTS_SVH

// Read-only register offsets
`define OFS_DATA_STATUS 8'h00
`define OFS_X_SAMPLE_HIGH 8'h01
`define OFS_X_SAMPLE_LOW 8'h02
`define OFS_Y_SAMPLE_HIGH 8'h03
`define OFS_Y_SAMPLE_LOW 8'h04
`define OFS_Z_SAMPLE_HIGH 8'h05
`define OFS_Z_SAMPLE_LOW 8'h06
`define OFS_SYSTEM_STATE 8'h0b
`define OFS_IRQ_PENDING 8'h0c
`define OFS_DEVICE_IDENTITY 8'h0d
`define OFS_ORIENT_STATE 8'h10
`define OFS_FALL_MOTION_SOURCE 8'h16
`define OFS_JOLT_SOURCE 8'h1e
`define OFS_TAP_SOURCE 8'h22

// Read/write register offsets
`define OFS_SAMPLE_RANGE 8'h0e
`define OFS_HIGHPASS 8'h0f
`define OFS_ORIENT_CFG 8'h11
`define OFS_ORIENT_DEBOUNCE 8'h12
`define OFS_ORIENT_ZLOCK 8'h13
`define OFS_ORIENT_THRESHOLD 8'h14
`define OFS_FALL_CFG 8'h15
`define OFS_FALL_THRESHOLD 8'h17
`define OFS_FALL_DEBOUNCE 8'h18
`define OFS_JOLT_CFG 8'h1d
`define OFS_JOLT_THRESHOLD 8'h1f
`define OFS_JOLT_DEBOUNCE 8'h20
`define OFS_TAP_CFG 8'h21
`define OFS_TAP_X_THS 8'h23
`define OFS_TAP_Y_THS 8'h24
`define OFS_TAP_Z_THS 8'h25
`define OFS_TAP_FIRST_TIMER 8'h26
`define OFS_TAP_LATENCY 8'h27
`define OFS_TAP_WINDOW 8'h28
`define OFS_SLEEP_COUNT 8'h29
`define OFS_CONTROL_ONE 8'h2a
`define OFS_CONTROL_TWO 8'h2b
`define OFS_WAKE_PIN_CTRL 8'h2c
`define OFS_IRQ_ENABLE 8'h2d
`define OFS_IRQ_ROUTING 8'h2e
`define OFS_X_TRIM 8'h2f
`define OFS_Y_TRIM 8'h30
`define OFS_Z_TRIM 8'h31
`define CFG_FIRST 8'h0e
`define CFG_LAST 8'h31

// Writable bits of each read/write register; others read zero
`define WMASK_SAMPLE_RANGE 8'h03
`define WMASK_HIGHPASS 8'h33
`define WMASK_ORIENT_CFG 8'hc0
`define WMASK_ORIENT_ZLOCK 8'hc7
`define WMASK_FALL_CFG 8'hf8
`define WMASK_JOLT_CFG 8'h1f
`define WMASK_TAP_THS 8'h7f
`define WMASK_CONTROL_TWO 8'hdf
`define WMASK_WAKE_PIN 8'h7b
`define WMASK_IRQ_MAP 8'hbd
`define WMASK_FULL 8'hff
`define WMASK_NONE 8'h00
`define REG_RESET 8'h00

// Interrupt source bit positions (enable, routing, pending)
`define IRQ_BIT_SLEEP_WAKE 7
`define IRQ_BIT_JOLT 5
`define IRQ_BIT_ORIENT 4
`define IRQ_BIT_TAP 3
`define IRQ_BIT_FALL_MOTION 2
`define IRQ_BIT_SAMPLE_READY 0

// Wake and pin control fields
`define WAKE_BIT_POLARITY 1
`define WAKE_BIT_DRIVE 0

// Data status fields
`define STAT_BIT_ALL_OVERWRITE 7
`define STAT_BIT_Z_OVERWRITE 6
`define STAT_BIT_Y_OVERWRITE 5
`define STAT_BIT_X_OVERWRITE 4
`define STAT_BIT_ALL_READY 3
`define STAT_BIT_Z_READY 2
`define STAT_BIT_Y_READY 1
`define STAT_BIT_X_READY 0

// Sample layout and trim scaling
`define LOW_PAD_BITS 6
`define SAMPLE_REG_STRIDE 2
`define TRIM_BASE_SHIFT 1
`define SAMPLE_MAX 10'sh1ff
`define SAMPLE_MIN 10'sh200

`endif

// File: axis_offset_pkg.sv
// Purpose: Shared types of the axis offset register map.
// Assumes: Ten-bit samples and byte-wide registers.
// Notes: Constants live in axis_offset_consts.svh.
package axis_offset_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic signed [9:0] sample_t;
  typedef logic signed [7:0] trim_t;
  // Full-scale selection held in the low bits of the range register
  typedef enum logic [1:0] {
    RANGE_2G,
    RANGE_4G,
    RANGE_8G,
    RANGE_RESERVED
  } range_t;
endpackage

// File: axis_offset_register_map.sv
// Purpose: Register map of a three-axis motion sensor with zero-g trim.
// Assumes: One clock, synchronous reset, byte register port.
// Notes: Detection engines sit outside and feed flags and sources in.
`timescale 1ns/1ps
`default_nettype none
`include "axis_offset_consts.svh"
module axis_offset_register_map
  import axis_offset_pkg::*;
#(
  parameter int AXES = 3,
  parameter int SAMPLE_W = 10,
  // Identity value is arbitrary
  parameter reg_byte_t IDENTITY = 8'ha5
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Raw samples from the converter
  input wire logic sample_valid,
  input wire logic [9:0] sample_x,
  input wire logic [9:0] sample_y,
  input wire logic [9:0] sample_z,
  // Detection engine status
  input wire logic [7:0] engine_flags,
  input wire logic [1:0] system_mode,
  input wire logic [7:0] orient_state_in,
  input wire logic [7:0] fall_motion_src_in,
  input wire logic [7:0] jolt_src_in,
  input wire logic [7:0] tap_src_in,
  // Settings handed to the engines
  output logic [7:0] wake_enables,
  output logic [1:0] range_select,
  // Interrupt pins
  output logic first_irq_pin_out,
  output logic first_irq_pin_oe,
  output logic second_irq_pin_out,
  output logic second_irq_pin_oe
);

  // Writable bits of each configuration offset
  function automatic reg_byte_t write_mask(input logic [7:0] a);
    if (a == `OFS_SAMPLE_RANGE) begin
      write_mask = `WMASK_SAMPLE_RANGE;
    end else if (a == `OFS_HIGHPASS) begin
      write_mask = `WMASK_HIGHPASS;
    end else if (a == `OFS_ORIENT_CFG) begin
      write_mask = `WMASK_ORIENT_CFG;
    end else if (a == `OFS_ORIENT_DEBOUNCE) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_ORIENT_ZLOCK) begin
      write_mask = `WMASK_ORIENT_ZLOCK;
    end else if (a == `OFS_ORIENT_THRESHOLD) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_FALL_CFG) begin
      write_mask = `WMASK_FALL_CFG;
    end else if (a == `OFS_FALL_THRESHOLD) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_FALL_DEBOUNCE) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_JOLT_CFG) begin
      write_mask = `WMASK_JOLT_CFG;
    end else if (a == `OFS_JOLT_THRESHOLD) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_JOLT_DEBOUNCE) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_TAP_CFG) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_TAP_X_THS) begin
      write_mask = `WMASK_TAP_THS;
    end else if (a == `OFS_TAP_Y_THS) begin
      write_mask = `WMASK_TAP_THS;
    end else if (a == `OFS_TAP_Z_THS) begin
      write_mask = `WMASK_TAP_THS;
    end else if (a == `OFS_TAP_FIRST_TIMER) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_TAP_LATENCY) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_TAP_WINDOW) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_SLEEP_COUNT) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_CONTROL_ONE) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_CONTROL_TWO) begin
      write_mask = `WMASK_CONTROL_TWO;
    end else if (a == `OFS_WAKE_PIN_CTRL) begin
      write_mask = `WMASK_WAKE_PIN;
    end else if (a == `OFS_IRQ_ENABLE) begin
      write_mask = `WMASK_IRQ_MAP;
    end else if (a == `OFS_IRQ_ROUTING) begin
      write_mask = `WMASK_IRQ_MAP;
    end else if (a == `OFS_X_TRIM) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_Y_TRIM) begin
      write_mask = `WMASK_FULL;
    end else if (a == `OFS_Z_TRIM) begin
      write_mask = `WMASK_FULL;
    end else begin
      write_mask = `WMASK_NONE;
    end
  endfunction

  localparam int CFG_N = int'(`CFG_LAST) - int'(`CFG_FIRST) + 1;

  // Configuration storage, indexed by offset minus the first offset
  reg_byte_t cfg [CFG_N];

  // Stored corrected samples, axis 0 is X
  sample_t stored [AXES];
  sample_t corrected [AXES];
  logic [AXES*SAMPLE_W-1:0] raw_all;

  // Data status flags
  logic [AXES-1:0] axis_ready;
  logic [AXES-1:0] axis_overwrite;
  logic all_ready;
  logic all_overwrite;

  // Decoded access strobes
  logic wr_hit;
  logic rd_hit;

  // Named views of key registers
  reg_byte_t irq_enable;
  reg_byte_t irq_routing;
  reg_byte_t wake_ctrl;
  reg_byte_t pending;
  reg_byte_t next_rdata;
  logic [1:0] range_bits;
  logic first_active;
  logic second_active;
  logic [AXES-1:0] high_read;

  assign wr_hit = clk_en && reg_wr;
  assign rd_hit = clk_en && reg_rd;
  assign irq_enable = cfg[int'(`OFS_IRQ_ENABLE - `CFG_FIRST)];
  assign irq_routing = cfg[int'(`OFS_IRQ_ROUTING - `CFG_FIRST)];
  assign wake_ctrl = cfg[int'(`OFS_WAKE_PIN_CTRL - `CFG_FIRST)];
  assign range_bits = cfg[int'(`OFS_SAMPLE_RANGE - `CFG_FIRST)][1:0];
  assign raw_all = {sample_z, sample_y, sample_x};

  // One storage byte per configuration offset
  genvar gi;
  generate
    for (gi = 0; gi < CFG_N; gi++) begin : g_cfg
      localparam logic [7:0] OFS = 8'(gi) + `CFG_FIRST;
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          cfg[gi] <= `REG_RESET;
        end else if (wr_hit && reg_addr == OFS) begin
          cfg[gi] <= reg_wdata & write_mask(OFS);
        end
      end
    end
  endgenerate

  // Trim adder and sample register per axis
  generate
    for (gi = 0; gi < AXES; gi++) begin : g_axis
      axis_trim_adder #(
        .SAMPLE_W(SAMPLE_W)
      ) u_trim (
        .raw(sample_t'(raw_all[gi*SAMPLE_W +: SAMPLE_W])),
        .trim(trim_t'(cfg[int'(`OFS_X_TRIM - `CFG_FIRST) + gi])),
        .range_sel(range_t'(range_bits)),
        .corrected(corrected[gi])
      );

      // Corrected sample stored on each new conversion
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          stored[gi] <= '0;
        end else if (clk_en && sample_valid) begin
          stored[gi] <= corrected[gi];
        end
      end

      // Reading the high byte of an axis retires its flags
      assign high_read[gi] = rd_hit &&
        reg_addr == `OFS_X_SAMPLE_HIGH + 8'(`SAMPLE_REG_STRIDE * gi);

      // Ready and overwrite flags; a new sample beats the clear
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          axis_ready[gi] <= 1'b0;
          axis_overwrite[gi] <= 1'b0;
        end else if (clk_en && sample_valid) begin
          axis_ready[gi] <= 1'b1;
          axis_overwrite[gi] <= axis_ready[gi] && !high_read[gi];
        end else if (high_read[gi]) begin
          axis_ready[gi] <= 1'b0;
          axis_overwrite[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Combined all-axis flags, retired when the Z high byte is read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      all_ready <= 1'b0;
      all_overwrite <= 1'b0;
    end else if (clk_en && sample_valid) begin
      all_ready <= 1'b1;
      all_overwrite <= all_ready && !high_read[AXES-1];
    end else if (high_read[AXES-1]) begin
      all_ready <= 1'b0;
      all_overwrite <= 1'b0;
    end
  end

  // Pending sources: engine levels and data ready, gated by enables
  always_comb begin
    pending = '0;
    pending[`IRQ_BIT_SLEEP_WAKE] = engine_flags[`IRQ_BIT_SLEEP_WAKE];
    pending[`IRQ_BIT_JOLT] = engine_flags[`IRQ_BIT_JOLT];
    pending[`IRQ_BIT_ORIENT] = engine_flags[`IRQ_BIT_ORIENT];
    pending[`IRQ_BIT_TAP] = engine_flags[`IRQ_BIT_TAP];
    pending[`IRQ_BIT_FALL_MOTION] = engine_flags[`IRQ_BIT_FALL_MOTION];
    pending[`IRQ_BIT_SAMPLE_READY] = all_ready;
    pending = pending & irq_enable;
  end

  // Pin selection by routing map
  assign first_active = |(pending & irq_routing);
  assign second_active = |(pending & ~irq_routing);

  // Read data mux, taken on the read strobe
  always_comb begin
    next_rdata = '0;
    if (reg_addr == `OFS_DATA_STATUS) begin
      next_rdata[`STAT_BIT_ALL_OVERWRITE] = all_overwrite;
      next_rdata[`STAT_BIT_Z_OVERWRITE] = axis_overwrite[2];
      next_rdata[`STAT_BIT_Y_OVERWRITE] = axis_overwrite[1];
      next_rdata[`STAT_BIT_X_OVERWRITE] = axis_overwrite[0];
      next_rdata[`STAT_BIT_ALL_READY] = all_ready;
      next_rdata[`STAT_BIT_Z_READY] = axis_ready[2];
      next_rdata[`STAT_BIT_Y_READY] = axis_ready[1];
      next_rdata[`STAT_BIT_X_READY] = axis_ready[0];
    end else if (reg_addr == `OFS_X_SAMPLE_HIGH) begin
      next_rdata = stored[0][9:2];
    end else if (reg_addr == `OFS_X_SAMPLE_LOW) begin
      next_rdata = {stored[0][1:0], `LOW_PAD_BITS'(0)};
    end else if (reg_addr == `OFS_Y_SAMPLE_HIGH) begin
      next_rdata = stored[1][9:2];
    end else if (reg_addr == `OFS_Y_SAMPLE_LOW) begin
      next_rdata = {stored[1][1:0], `LOW_PAD_BITS'(0)};
    end else if (reg_addr == `OFS_Z_SAMPLE_HIGH) begin
      next_rdata = stored[2][9:2];
    end else if (reg_addr == `OFS_Z_SAMPLE_LOW) begin
      next_rdata = {stored[2][1:0], `LOW_PAD_BITS'(0)};
    end else if (reg_addr == `OFS_SYSTEM_STATE) begin
      next_rdata = {6'(0), system_mode};
    end else if (reg_addr == `OFS_IRQ_PENDING) begin
      next_rdata = pending;
    end else if (reg_addr == `OFS_DEVICE_IDENTITY) begin
      next_rdata = IDENTITY;
    end else if (reg_addr == `OFS_ORIENT_STATE) begin
      next_rdata = orient_state_in;
    end else if (reg_addr == `OFS_FALL_MOTION_SOURCE) begin
      next_rdata = fall_motion_src_in;
    end else if (reg_addr == `OFS_JOLT_SOURCE) begin
      next_rdata = jolt_src_in;
    end else if (reg_addr == `OFS_TAP_SOURCE) begin
      next_rdata = tap_src_in;
    end else if (reg_addr >= `CFG_FIRST && reg_addr <= `CFG_LAST) begin
      next_rdata = cfg[int'(reg_addr - `CFG_FIRST)];
    end
  end

  // Registered read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (rd_hit) begin
      reg_rdata <= next_rdata;
    end
  end

  // Settings mirrored to the engines
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_enables <= '0;
      range_select <= '0;
    end else if (clk_en) begin
      wake_enables <= wake_ctrl;
      range_select <= range_bits;
    end
  end

  // Pin levels: active level equals polarity, idle is its inverse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_irq_pin_out <= 1'b1;
      second_irq_pin_out <= 1'b1;
    end else if (clk_en) begin
      first_irq_pin_out <= first_active ~^
        wake_ctrl[`WAKE_BIT_POLARITY];
      second_irq_pin_out <= second_active ~^
        wake_ctrl[`WAKE_BIT_POLARITY];
    end
  end

  // Pin enables; open drain lets several parts share one line
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_irq_pin_oe <= 1'b1;
      second_irq_pin_oe <= 1'b1;
    end else if (clk_en) begin
      // Open drain releases the pin while idle
      first_irq_pin_oe <= !wake_ctrl[`WAKE_BIT_DRIVE] ||
        first_active;
      second_irq_pin_oe <= !wake_ctrl[`WAKE_BIT_DRIVE] ||
        second_active;
    end
  end

endmodule
`default_nettype wire

// File: axis_trim_adder.sv
// Purpose: Adds a scaled zero-g trim to one raw axis sample.
// Assumes: Trim is 2 mg per step; sample step depends on full scale.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "axis_offset_consts.svh"
module axis_trim_adder
  import axis_offset_pkg::*;
#(
  parameter int SAMPLE_W = 10
) (
  // Operands
  input wire sample_t raw,
  input wire trim_t trim,
  input wire range_t range_sel,
  // Result
  output sample_t corrected
);
  logic signed [SAMPLE_W+1:0] wide_raw;
  logic signed [SAMPLE_W+1:0] wide_trim;
  logic signed [SAMPLE_W+1:0] sum;
  logic [2:0] shift;

  // Scale trim to sample steps and add with saturation
  always_comb begin
    // Three bits so the reserved range can shift by four
    shift = 3'(`TRIM_BASE_SHIFT) + 3'(range_sel);
    wide_raw = (SAMPLE_W+2)'(raw);
    wide_trim = (SAMPLE_W+2)'(trim) >>> shift;
    sum = wide_raw + wide_trim;
    if (sum > (SAMPLE_W+2)'(`SAMPLE_MAX)) begin
      corrected = `SAMPLE_MAX;
    end else if (sum < (SAMPLE_W+2)'(`SAMPLE_MIN)) begin
      corrected = `SAMPLE_MIN;
    end else begin
      corrected = sum[SAMPLE_W-1:0];
    end
  end
endmodule
`default_nettype wire

// File: tb_axis_offset_register_map.sv
// Purpose: Self-checking bench for the axis offset register map.
// Assumes: Inputs change on the falling edge of a 50 MHz clock.
// Notes: Expected values come from the trim and layout rules.
`timescale 1ns/1ps
`default_nettype none
module tb_axis_offset_register_map;
  import axis_offset_pkg::*;
  logic clk_sys, srst, clk_en, sample_valid, reg_wr, reg_rd;
  logic [9:0] sample_x, sample_y, sample_z;
  logic [7:0] engine_flags, reg_addr, reg_wdata, reg_rdata, wake_enables;
  logic [7:0] rv;
  logic [1:0] range_select;
  logic p1, p1_oe, p2, p2_oe;
  int failures = 0;
  int checks = 0;
  logic [7:0] ofs [6] = '{8'h2f, 8'h30, 8'h31, 8'h2c, 8'h2d, 8'h2e};
  logic [7:0] msk [6] = '{8'hff, 8'hff, 8'hff, 8'h7b, 8'hbd, 8'hbd};
  axis_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  axis_offset_register_map dut (.clk_sys(clk_sys), .srst(srst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z),
    .engine_flags(engine_flags), .system_mode(2'b00),
    .orient_state_in(8'h00), .fall_motion_src_in(8'h00),
    .jolt_src_in(8'h00), .tap_src_in(8'h00),
    .wake_enables(wake_enables), .range_select(range_select),
    .first_irq_pin_out(p1), .first_irq_pin_oe(p1_oe),
    .second_irq_pin_out(p2), .second_irq_pin_oe(p2_oe));
  // Free-running clock
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check("register", rv, exp);
  endtask
  // Saturated sum of raw sample and scaled trim
  function automatic logic [9:0] corr(input logic [9:0] raw,
      input logic [7:0] t, input int sh);
    int s;
    s = $signed(raw) + ($signed(t) >>> sh);
    if (s > 511) s = 511;
    if (s < -512) s = -512;
    return s[9:0];
  endfunction
  task automatic axis_chk(input logic [7:0] a, input logic [9:0] e);
    rdchk(a, e[9:2]);
    rdchk(a + 8'h01, {e[1:0], 6'b000000});
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    sample_valid = 1'b0;
    sample_x = 10'h000;
    sample_y = 10'h000;
    sample_z = 10'h000;
    engine_flags = 8'h00;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    foreach (ofs[i]) begin
      rdchk(ofs[i], 8'h00);
      host.wr(ofs[i], 8'hff);
      rdchk(ofs[i], msk[i]);
    end
    rdchk(8'h40, 8'h00);
    host.wr(8'h2f, 8'h10);
    host.wr(8'h30, 8'h80);
    host.wr(8'h31, 8'h7f);
    host.wr(8'h2c, 8'h00);
    host.wr(8'h2d, 8'h01);
    host.wr(8'h2e, 8'h01);
    // Every full-scale setting, reserved one included
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h0e, r[7:0]);
      host.idle();
      check("range", {6'h00, range_select}, r[7:0]);
      sample_x = 10'h001;
      sample_y = 10'h200;
      sample_z = 10'h1ff;
      sample_valid = 1'b1;
      @(negedge clk_sys);
      sample_valid = 1'b0;
      sample_x = ~sample_x;
      @(negedge clk_sys);
      check("first pin", {7'h00, p1}, 8'h00);
      check("second pin", {7'h00, p2}, 8'h01);
      rdchk(8'h00, 8'h0f);
      host.service(rv);
      check("pending", rv, 8'h01);
      axis_chk(8'h01, corr(10'h001, 8'h10, r + 1));
      axis_chk(8'h03, corr(10'h200, 8'h80, r + 1));
      axis_chk(8'h05, corr(10'h1ff, 8'h7f, r + 1));
    end
    engine_flags = 8'h24;
    host.wr(8'h2d, 8'h24);
    host.wr(8'h2e, 8'h04);
    host.wr(8'h2c, 8'h02);
    host.idle();
    @(negedge clk_sys);
    check("first pin", {7'h00, p1}, 8'h01);
    check("second pin", {7'h00, p2}, 8'h01);
    host.service(rv);
    check("pending", rv, 8'h24);
    host.wr(8'h2d, 8'h04);
    host.wr(8'h2c, 8'h03);
    host.idle();
    @(negedge clk_sys);
    check("wake copy", wake_enables, 8'h03);
    check("second oe", {7'h00, p2_oe}, 8'h00);
    check("first oe", {7'h00, p1_oe}, 8'h01);
    check("first pin", {7'h00, p1}, 8'h01);
    clk_en = 1'b0;
    host.wr(8'h2f, 8'h55);
    host.idle();
    clk_en = 1'b1;
    rdchk(8'h2f, 8'h10);
    host.idle();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
